// [rbmc_pkg.sv]
/*
  rbmc_pkg: constants and types shared by the reset, boot and memory control block.
  Assumes a single slow-clock domain (clk_sys) and a 32-bit internal address bus.
*/
package rbmc_pkg;

  // ************
  // synchroniser and strap window
  // ************
  localparam int SYNC_W = 8;               // number of pin inputs passed through two flops
  localparam int IDX_MODE_LOW = 0;         // mode_pin_low
  localparam int IDX_MODE_HIGH = 1;        // mode_pin_high
  localparam int IDX_BOOT_STRAP = 2;       // boot_width_strap
  localparam int IDX_TRI_STRAP_N = 3;      // tristate_strap_n
  localparam int IDX_TAP_CHOOSER = 4;      // tap_port_chooser
  localparam int IDX_PROTECT = 5;          // protect_enable_pin
  localparam int IDX_OSC_PIN = 6;          // osc_input_pin
  localparam int IDX_INT_OSC = 7;          // internal oscillator output
  localparam int STRAP_WINDOW = 10;        // slow-clock cycles before release that are sampled
  localparam logic [3:0] WD_RESET_CYCLES = 4'hA;  // length of an internal watchdog reset

  // ************
  // address map
  // ************
  localparam logic [31:0] INT_MEM_TOP = 32'h0040_0000;  // first address above internal memories
  localparam logic [31:0] EXT_TOP = 32'hFFC0_0000;      // first address of internal peripherals
  localparam logic [2:0] BOOT_CS = 3'h0;                // chip select that holds the boot memory

  // ************
  // reset values
  // ************
  localparam logic RST_BOOT_WIDTH8 = 1'b0;
  localparam logic RST_TRISTATE = 1'b0;
  localparam logic RST_REMAPPED = 1'b0;

  // ************
  // types
  // ************
  // mode pin code, written {mode_pin_low, mode_pin_high}
  typedef enum logic [1:0] {
    RBMC_MODE_NORMAL_OSC = 2'b00,
    RBMC_MODE_BSCAN = 2'b01,
    RBMC_MODE_BYPASS = 2'b10,
    RBMC_MODE_TEST = 2'b11
  } rbmc_mode_t;

  typedef enum logic [1:0] {
    RBMC_ST_PIN_RST = 2'b00,
    RBMC_ST_WD_RST = 2'b01,
    RBMC_ST_RUN = 2'b10
  } rbmc_rst_state_t;

  typedef enum logic [1:0] {
    RBMC_SIZE_BYTE = 2'b00,
    RBMC_SIZE_HALF = 2'b01,
    RBMC_SIZE_WORD = 2'b10
  } rbmc_size_t;

endpackage

// [rbmc_rst_if.sv]
/*
  rbmc_rst_if: carries the synchronised reset levels from the reset synchroniser to the control core.
  Assumes both ends run on clk_sys.
*/
`timescale 1ns/1ps
interface rbmc_rst_if;
  logic pinRstActive;   // chip reset pin active, released in step with clk_sys
  logic testRstActive;  // test port reset active, released in step with clk_sys

  modport src (output pinRstActive, output testRstActive);
  modport dst (input pinRstActive, input testRstActive);
endinterface

// [rbmc_rst_sync.sv]
/*
  rbmc_rst_sync: reset synchronisers for the chip reset pin and the test port reset pin.
  Assumes both pins are asynchronous and active low; assertion acts at once, release after two flops.
*/
`timescale 1ns/1ps
module rbmc_rst_sync
  import rbmc_pkg::*;
(
  // clock and power-on reset
  input wire logic clk_sys,
  input wire logic chip_reset_n,
  // reset pins
  input wire logic chipResetN,
  input wire logic testPortResetN,
  // synchronised levels
  rbmc_rst_if.src rst
);

  typedef struct packed {
    logic [1:0] pinChain;
  } rbmc_pin_sync_t;

  rbmc_pin_sync_t st;
  rbmc_pin_sync_t next_st;
  logic [1:0] testChain;

  // ************
  // chip reset chain
  // ************
  // shift ones in; the first stage feeds only the second
  always_comb begin
    next_st = st;
    next_st.pinChain = {st.pinChain[0], 1'b1};
  end

  // enter reset without the clock, leave it two edges later [R7]
  always_ff @(posedge clk_sys or negedge chipResetN) begin
    if (!chipResetN) begin
      st <= '0;
    end else if (!chip_reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ************
  // test reset chain, kept apart from the chip reset [R10]
  // ************
  always_ff @(posedge clk_sys or negedge testPortResetN) begin
    if (!testPortResetN) begin
      testChain <= 2'h0;
    end else if (!chip_reset_n) begin
      testChain <= 2'h0;
    end else begin
      testChain <= {testChain[0], 1'b1};
    end
  end

  // levels towards the core
  assign rst.pinRstActive = ~st.pinChain[1];
  assign rst.testRstActive = ~testChain[1];

endmodule

// [rbmc_top.sv]
/*
  rbmc_top: reset, mode, strap, clock-out and address-space control of a microcontroller.
  Assumes clk_sys is the slow clock, the bus request comes from logic on clk_sys,
  and pins, straps and oscillator levels arrive asynchronously.
*/
`timescale 1ns/1ps

// Function
// R1 - mode pins 00 oscillator, 01 boundary scan, 10 external clock, 11 test
// R2 - outside party does full chip and test reset after any mode change
// R3 - in bypass mode the oscillator input pin is the slow clock
// R4 - clock output shows the slow clock during and after reset
// R5 - reset restores defaults and forces fetch from address zero
// R6 - during reset address lines low and peripheral clocks off
// R7 - enter reset at once, leave it synchronised to the slow clock
// R8 - outside party holds chip reset at least ten slow cycles
// R9 - straps sampled over the ten cycles before reset release
// R10 - chip reset leaves debug logic alone; only test reset clears it
// R11 - test reset goes to the port chosen after last chip reset
// R12 - watchdog reset acts like chip reset but keeps strap values
// R13 - pin reset wins over coinciding watchdog reset
// R14 - tristate strap low all ten cycles turns all drivers off
// R15 - boundary scan instructions supported; debug mode gives non-standard identity
// R16 - address split: internal low 4MB, peripherals top 4MB, external between
// R17 - external unit covers middle space with configurable banks
// R18 - protection blocks user access to defined peripherals when enabled
// R19 - forbidden peripheral write dropped, no abort from peripherals or memory reads
// R20 - boot strap 1 gives 8-bit boot memory, 0 gives 16-bit
// R21 - remap puts SRAM at zero, opens chip selects 1-7 until reset
// R22 - abort on undefined external address or misalignment; last abort recorded
// R23 - mode pins captured during chip reset, later changes ignored
module rbmc_top
  import rbmc_pkg::*;
(
  // clock and power-on reset
  input wire logic clk_sys,
  input wire logic chip_reset_n,
  // reset pins and watchdog
  input wire logic chipResetN,
  input wire logic testPortResetN,
  input wire logic wdResetReq,
  // mode and strap pins
  input wire logic modePinLow,
  input wire logic modePinHigh,
  input wire logic bootWidthStrap,
  input wire logic tristateStrapN,
  input wire logic tapPortChooser,
  input wire logic protectEnablePin,
  // oscillator levels
  input wire logic oscInputPin,
  input wire logic intOscLevel,
  // configuration from other system logic
  input wire logic protectPinFunc,
  input wire logic periphClkReq,
  input wire logic remapWrite,
  input wire logic remapData,
  // processor bus request
  input wire logic busValid,
  input wire logic [31:0] busAddr,
  input wire logic busWrite,
  input wire logic busFetch,
  input wire logic [1:0] busSize,
  input wire logic busUserMode,
  input wire logic periphDefined,
  input wire logic extBankHit,
  input wire logic [2:0] extBankCs,
  // reset and mode outputs
  output logic coreResetN,
  output logic fetchFromZero,
  output logic extAddrForceLow,
  output logic periphClkEn,
  output logic lastResetWd,
  output logic [1:0] modeCode,
  output logic oscBypass,
  output logic boundaryScanMode,
  output logic testMode,
  output logic iceIdNonStd,
  output logic debugResetN,
  output logic bscanTapResetN,
  output logic iceTapResetN,
  output logic clockOutPin,
  output logic outDriversOff,
  output logic bootWidth8,
  // address decode outputs
  output logic accValid,
  output logic regionInternal,
  output logic regionExternal,
  output logic regionPeriph,
  output logic selSram,
  output logic selBoot,
  output logic [6:0] csEnable,
  output logic periphCancel,
  output logic remapped,
  // abort outputs
  output logic abortPulse,
  output logic abortPrefetch,
  output logic abortMisalign,
  output logic [31:0] abortAddr
);

  // ************
  // state
  // ************
  typedef struct packed {
    logic [SYNC_W-1:0] sync1;
    logic [SYNC_W-1:0] sync2;
    rbmc_rst_state_t state;
    logic [3:0] wdCount;
    logic [STRAP_WINDOW-1:0] triHist;
    logic [STRAP_WINDOW-1:0] bootHist;
    logic [1:0] modeCode;
    logic tapChoice;
    logic coreResetN;
    logic fetchFromZero;
    logic extAddrForceLow;
    logic periphClkEn;
    logic lastResetWd;
    logic debugResetN;
    logic bscanTapResetN;
    logic iceTapResetN;
    logic clockOut;
    logic tristate;
    logic bootWidth8;
    logic remapped;
    logic accValid;
    logic regionInternal;
    logic regionExternal;
    logic regionPeriph;
    logic selSram;
    logic selBoot;
    logic [6:0] csEnable;
    logic periphCancel;
    logic abortPulse;
    logic abortPrefetch;
    logic abortMisalign;
    logic [31:0] abortAddr;
  } rbmc_state_t;

  rbmc_state_t st;
  rbmc_state_t next_st;
  rbmc_rst_if rstIf ();

  logic [SYNC_W-1:0] pinIn;
  logic pinRelease;
  logic inReset;
  logic misaligned;
  logic isInternal;
  logic isPeriph;
  logic csOpen;
  logic protectActive;
  logic abortNow;

  // ************
  // reset synchronisers
  // ************
  rbmc_rst_sync u_rst_sync (
    .clk_sys(clk_sys),
    .chip_reset_n(chip_reset_n),
    .chipResetN(chipResetN),
    .testPortResetN(testPortResetN),
    .rst(rstIf.src)
  );

  // gather the asynchronous pin levels for the two-flop synchroniser
  always_comb begin
    pinIn = '0;
    pinIn[IDX_MODE_LOW] = modePinLow;
    pinIn[IDX_MODE_HIGH] = modePinHigh;
    pinIn[IDX_BOOT_STRAP] = bootWidthStrap;
    pinIn[IDX_TRI_STRAP_N] = tristateStrapN;
    pinIn[IDX_TAP_CHOOSER] = tapPortChooser;
    pinIn[IDX_PROTECT] = protectEnablePin;
    pinIn[IDX_OSC_PIN] = oscInputPin;
    pinIn[IDX_INT_OSC] = intOscLevel;
  end

  // ************
  // decode helpers
  // ************
  // release seen while still in the pin reset state
  assign pinRelease = (st.state == RBMC_ST_PIN_RST) && !rstIf.pinRstActive;
  assign inReset = (st.state != RBMC_ST_RUN);

  // address space split, little-endian throughout [R16]
  assign isInternal = busAddr < INT_MEM_TOP;
  assign isPeriph = busAddr >= EXT_TOP;

  // half words need bit 0 clear, words need bits 1:0 clear
  assign misaligned = ((busSize == RBMC_SIZE_HALF) && busAddr[0]) ||
                      ((busSize == RBMC_SIZE_WORD) && (busAddr[1:0] != 2'h0));

  // chip selects other than the boot one only after remap [R17] [R21]
  assign csOpen = st.remapped || (extBankCs == BOOT_CS);

  // protection needs the pin high and in its peripheral function [R18]
  assign protectActive = st.sync2[IDX_PROTECT] && protectPinFunc;

  // external undefined or misaligned aborts; peripherals and memory reads never [R19] [R22]
  assign abortNow = busValid && !isPeriph &&
                    ((!isInternal && (!extBankHit || !csOpen)) ||
                     (misaligned && !(isInternal && !busWrite)));

  // ************
  // next state
  // ************
  always_comb begin
    next_st = st;

    // two-flop synchroniser for every pin input
    next_st.sync1 = pinIn;
    next_st.sync2 = st.sync1;

    // reset sequencer, pin reset first [R13]
    case (st.state)
      RBMC_ST_PIN_RST: begin
        if (!rstIf.pinRstActive) begin
          next_st.state = RBMC_ST_RUN;
        end
      end
      RBMC_ST_WD_RST: begin
        if (rstIf.pinRstActive) begin
          next_st.state = RBMC_ST_PIN_RST;
        end else if (st.wdCount == 4'h1) begin
          next_st.state = RBMC_ST_RUN;
        end
      end
      RBMC_ST_RUN: begin
        if (rstIf.pinRstActive) begin
          next_st.state = RBMC_ST_PIN_RST;
        end else if (wdResetReq) begin
          next_st.state = RBMC_ST_WD_RST;
        end
      end
      default: begin
        next_st.state = RBMC_ST_PIN_RST;
      end
    endcase

    // watchdog reset length counter
    if (st.state == RBMC_ST_RUN && wdResetReq && !rstIf.pinRstActive) begin
      next_st.wdCount = WD_RESET_CYCLES;
    end else if (st.wdCount != 4'h0) begin
      next_st.wdCount = st.wdCount - 4'h1;
    end

    // cause of the latest reset
    if (rstIf.pinRstActive) begin
      next_st.lastResetWd = 1'b0;   // [R13]
    end else if (st.state == RBMC_ST_RUN && wdResetReq) begin
      next_st.lastResetWd = 1'b1;
    end

    // strap history shifts only during the pin reset [R9] [R12]
    if (st.state == RBMC_ST_PIN_RST) begin
      next_st.triHist = {st.triHist[STRAP_WINDOW-2:0], st.sync2[IDX_TRI_STRAP_N]};
      next_st.bootHist = {st.bootHist[STRAP_WINDOW-2:0], st.sync2[IDX_BOOT_STRAP]};
      next_st.modeCode = {st.sync2[IDX_MODE_LOW], st.sync2[IDX_MODE_HIGH]};  // [R23]
    end

    // strap results taken at release of the pin reset only
    if (pinRelease) begin
      next_st.tristate = (st.triHist == '0);      // low throughout the window [R14]
      next_st.bootWidth8 = st.bootHist[0];        // 1 = 8-bit, 0 = 16-bit [R20]
      next_st.tapChoice = st.sync2[IDX_TAP_CHOOSER];  // [R11]
    end

    // core and pad control during any reset [R5] [R6]
    next_st.coreResetN = !(inReset || rstIf.pinRstActive);
    next_st.fetchFromZero = inReset || rstIf.pinRstActive;
    next_st.extAddrForceLow = inReset || rstIf.pinRstActive;
    next_st.periphClkEn = !inReset && !rstIf.pinRstActive && periphClkReq;

    // debug and tap resets follow the test reset pin alone [R10] [R11]
    next_st.debugResetN = !rstIf.testRstActive;
    next_st.bscanTapResetN = !(rstIf.testRstActive && st.tapChoice);
    next_st.iceTapResetN = !(rstIf.testRstActive && !st.tapChoice);

    // slow clock image; bypass takes the oscillator pin [R3] [R4]
    if (st.modeCode == RBMC_MODE_BYPASS) begin
      next_st.clockOut = st.sync2[IDX_OSC_PIN];
    end else begin
      next_st.clockOut = st.sync2[IDX_INT_OSC];
    end

    // remap set by a written one, cleared by either reset [R21]
    if (inReset || rstIf.pinRstActive) begin
      next_st.remapped = RST_REMAPPED;
    end else if (remapWrite && remapData) begin
      next_st.remapped = 1'b1;
    end

    // per-access decode, one cycle after the request
    next_st.accValid = busValid && !inReset;
    next_st.regionInternal = busValid && isInternal;
    next_st.regionPeriph = busValid && isPeriph;
    next_st.regionExternal = busValid && !isInternal && !isPeriph;  // [R17]
    next_st.selSram = busValid && isInternal && st.remapped;
    next_st.selBoot = busValid && isInternal && !st.remapped;
    next_st.csEnable = st.remapped ? 7'h7F : 7'h00;
    // user access to a defined, protected peripheral is dropped silently [R18] [R19]
    next_st.periphCancel = busValid && isPeriph && protectActive && busUserMode && periphDefined;

    // abort raised, access still proceeds; last one kept [R22]
    next_st.abortPulse = abortNow && !inReset;
    if (abortNow && !inReset) begin
      next_st.abortPrefetch = busFetch;
      next_st.abortMisalign = misaligned;
      next_st.abortAddr = busAddr;
    end
  end

  // ************
  // registers
  // ************
  // power-on reset clears all but fetchFromZero and extAddrForceLow, which it sets; straps keep defaults until sampled
  always_ff @(posedge clk_sys) begin
    if (!chip_reset_n) begin
      st <= '0;
      st.state <= RBMC_ST_PIN_RST;
      st.coreResetN <= 1'b0;
      st.fetchFromZero <= 1'b1;
      st.extAddrForceLow <= 1'b1;
      st.debugResetN <= 1'b0;
      st.bscanTapResetN <= 1'b0;
      st.iceTapResetN <= 1'b0;
      st.tristate <= RST_TRISTATE;
      st.bootWidth8 <= RST_BOOT_WIDTH8;
      st.remapped <= RST_REMAPPED;
    end else begin
      st <= next_st;
    end
  end

  // ************
  // outputs straight from flops; mode flags decoded from the mode code flops
  // ************
  // mode decode [R1] [R15]
  assign modeCode = st.modeCode;
  assign oscBypass = (st.modeCode == RBMC_MODE_BYPASS);
  assign boundaryScanMode = (st.modeCode == RBMC_MODE_BSCAN);
  assign testMode = (st.modeCode == RBMC_MODE_TEST);
  assign iceIdNonStd = !st.modeCode[0];   // debug mode when mode_pin_high is low
  assign coreResetN = st.coreResetN;
  assign fetchFromZero = st.fetchFromZero;
  assign extAddrForceLow = st.extAddrForceLow;
  assign periphClkEn = st.periphClkEn;
  assign lastResetWd = st.lastResetWd;
  assign debugResetN = st.debugResetN;
  assign bscanTapResetN = st.bscanTapResetN;
  assign iceTapResetN = st.iceTapResetN;
  assign clockOutPin = st.clockOut;
  assign outDriversOff = st.tristate;
  assign bootWidth8 = st.bootWidth8;
  assign accValid = st.accValid;
  assign regionInternal = st.regionInternal;
  assign regionExternal = st.regionExternal;
  assign regionPeriph = st.regionPeriph;
  assign selSram = st.selSram;
  assign selBoot = st.selBoot;
  assign csEnable = st.csEnable;
  assign periphCancel = st.periphCancel;
  assign remapped = st.remapped;
  assign abortPulse = st.abortPulse;
  assign abortPrefetch = st.abortPrefetch;
  assign abortMisalign = st.abortMisalign;
  assign abortAddr = st.abortAddr;

endmodule

// [rbmc_checker.sv]
/*
  rbmc_checker: port-level checks of rbmc_top.
  Assumes one clock, clk_sys, and synchronous active-low chip_reset_n.
*/
`timescale 1ns/1ps
module rbmc_checker
  import rbmc_pkg::*;
(
  // clock and resets
  input wire logic clk_sys,
  input wire logic chip_reset_n,
  input wire logic chipResetN,
  input wire logic testPortResetN,
  input wire logic wdResetReq,
  // inputs watched
  input wire logic intOscLevel,
  input wire logic oscInputPin,
  input wire logic remapWrite,
  input wire logic remapData,
  input wire logic busValid,
  input wire logic [31:0] busAddr,
  input wire logic busWrite,
  input wire logic [1:0] busSize,
  input wire logic extBankHit,
  // outputs watched
  input wire logic coreResetN,
  input wire logic fetchFromZero,
  input wire logic extAddrForceLow,
  input wire logic periphClkEn,
  input wire logic [1:0] modeCode,
  input wire logic oscBypass,
  input wire logic boundaryScanMode,
  input wire logic debugResetN,
  input wire logic clockOutPin,
  input wire logic remapped,
  input wire logic abortPulse,
  input wire logic abortMisalign,
  input wire logic regionPeriph
);
  // ************
  // checks
  // ************
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!chip_reset_n);
  // a request counts only with no reset pending
  logic live;
  assign live = busValid && coreResetN && chipResetN && !wdResetReq;

  AST_RST_OUTS: assert property (!coreResetN |-> fetchFromZero && extAddrForceLow && !periphClkEn)
    else $error("reset outputs wrong");
  AST_PIN_ENTER: assert property ($fell(chipResetN) |-> ##[1:4] !coreResetN)
    else $error("pin reset not entered");
  AST_WD_ENTER: assert property (coreResetN && chipResetN && wdResetReq |-> ##[1:3] !coreResetN)
    else $error("watchdog reset not entered");
  AST_MODE_DEC: assert property (oscBypass == (modeCode == 2'h2) && boundaryScanMode == (modeCode == 2'h1))
    else $error("mode decode wrong");
  AST_CLK_OUT: assert property ((!oscBypass)[*4] ##0 $past(chip_reset_n, 3) |-> clockOutPin == $past(intOscLevel, 3))
    else $error("clock out wrong");
  AST_CLK_BYP: assert property (oscBypass[*4] ##0 $past(chip_reset_n, 3) |-> clockOutPin == $past(oscInputPin, 3))
    else $error("bypass clock out wrong");
  AST_DBG_KEEP: assert property (testPortResetN[*4] ##0 $past(debugResetN) |-> debugResetN)
    else $error("debug logic reset without test reset");
  AST_EXT_ABORT: assert property (live && busAddr >= INT_MEM_TOP && busAddr < EXT_TOP && !extBankHit |=> abortPulse)
    else $error("external abort missing");
  AST_PERIPH_OK: assert property (live && busAddr >= EXT_TOP |=> !abortPulse && regionPeriph)
    else $error("peripheral access wrong");
  AST_MISALIGN: assert property (live && busWrite && busSize == 2'h2 && busAddr[1:0] != 2'h0 && busAddr < EXT_TOP
    |=> abortPulse && abortMisalign)
    else $error("misaligned write not aborted");
  AST_REMAP_SET: assert property (live && remapWrite && remapData |-> ##[1:2] remapped)
    else $error("remap not taken");
  AST_REMAP_CLR: assert property ($fell(coreResetN) |-> ##[0:2] !remapped)
    else $error("remap survived reset");

  CV_ABORT: cover property (abortPulse);
  CV_REMAP: cover property ($rose(remapped));
  CV_WD: cover property (coreResetN && wdResetReq);
endmodule

bind rbmc_top rbmc_checker chk (.*);

// [rbmc_board_model.sv]
/*
  rbmc_board_model: board reset circuit driving chip and test reset pins.
  Assumes the bench raises go for one cycle per reset pulse.
*/
`timescale 1ns/1ps
module rbmc_board_model (
  // clock
  input wire logic clk_sys,
  // commands from the bench
  input wire logic go,
  input wire logic withTest,
  input wire logic [7:0] holdCycles,
  // reset pins, both low at power-up until the oscillator is steady
  output logic chipResetN = 1'b0,
  output logic testPortResetN = 1'b0
);
  int cnt = 30;
  // count the hold time, never shorter than ten cycles
  always @(posedge clk_sys) begin
    if (cnt > 0) begin
      cnt <= cnt - 1;
      if (cnt == 1) begin
        chipResetN <= 1'b1;
        testPortResetN <= 1'b1;
      end
    end else if (go) begin
      cnt <= (holdCycles < 8'hA) ? 10 : int'(holdCycles);
      chipResetN <= 1'b0;
      testPortResetN <= !withTest;
    end
  end
endmodule

// [tb_top.sv]
/*
  tb_top: self-checking bench of rbmc_top with a board reset model.
  Assumes 50 MHz clk_sys; bench inputs change on the falling edge.
*/
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
  begin \
    samples_checked++; \
    if ((got) !== (ex)) begin \
      miscompares++; \
      $display("BAD %s exp %0h got %0h", nm, ex, got); \
    end \
  end
module tb_top;
  import rbmc_pkg::*;
  logic clk_sys = 1'b0, chip_reset_n = 1'b0, go = 1'b0, withTest = 1'b0, chipResetN, testPortResetN;
  logic [7:0] holdCycles = 8'h0;
  logic wdResetReq = 1'b0, modePinLow = 1'b0, modePinHigh = 1'b0, bootWidthStrap = 1'b0, tristateStrapN = 1'b1;
  logic tapPortChooser = 1'b0, protectEnablePin = 1'b0, oscInputPin = 1'b0, intOscLevel = 1'b0;
  logic protectPinFunc = 1'b0, periphClkReq = 1'b1, remapWrite = 1'b0, remapData = 1'b0, busValid = 1'b0;
  logic busWrite = 1'b0, busFetch = 1'b0, busUserMode = 1'b0, periphDefined = 1'b0, extBankHit = 1'b0;
  logic [31:0] busAddr = 32'h0, a, r, abortAddr;
  logic [1:0] busSize = 2'h0, modeCode;
  logic [2:0] extBankCs = 3'h0, oscCnt = 3'h0;
  logic coreResetN, fetchFromZero, extAddrForceLow, periphClkEn, lastResetWd, oscBypass, boundaryScanMode;
  logic testMode, iceIdNonStd, debugResetN, bscanTapResetN, iceTapResetN, outDriversOff, bootWidth8, accValid;
  logic regionInternal, regionExternal, regionPeriph, periphCancel, remapped, abortPulse, abortPrefetch;
  logic abortMisalign, selSram, selBoot, expRemap = 1'b0, expTap = 1'b0;
  logic [6:0] csEnable;
  logic [31:0] edges [4] = '{32'h003F_FFFC, 32'h0040_0000, 32'hFFBF_FFFC, 32'hFFC0_0000};
  int miscompares = 0, samples_checked = 0, seed = 32'hECF9;

  // ************
  // clock, oscillator levels, instances
  // ************
  always #10 clk_sys = ~clk_sys;
  always @(negedge clk_sys) begin
    oscCnt <= oscCnt + 3'h1;
    intOscLevel <= oscCnt[1];
    oscInputPin <= oscCnt[2];
  end
  rbmc_board_model board (.*);
  rbmc_top dut (.*, .clockOutPin());

  // ************
  // tasks
  // ************
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // bounded wait for the core reset level
  task automatic wait_core(input logic v);
    int n;
    n = 0;
    while (coreResetN !== v && n < 300) begin
      @(negedge clk_sys);
      n++;
    end
    if (coreResetN !== v) begin
      `CHK("coreResetN", v, coreResetN)
      wrap_up;
    end
  endtask
  // pin reset pulse, optionally with a watchdog request in the same cycle
  task automatic pulse(input int h, input logic t, input logic w);
    go = 1'b1;
    wdResetReq = w;
    holdCycles = h[7:0];
    withTest = t;
    @(negedge clk_sys);
    go = 1'b0;
    wdResetReq = 1'b0;
    wait_core(1'b0);
    repeat (4) @(negedge clk_sys);
    `CHK("fetchFromZero", 1'b1, fetchFromZero)
    `CHK("extAddrForceLow", 1'b1, extAddrForceLow)
    `CHK("periphClkEn", 1'b0, periphClkEn)
    `CHK("debugResetN", !t, debugResetN)
    `CHK("tapRst", ({!(t && expTap), !(t && !expTap)}), ({bscanTapResetN, iceTapResetN}))
    expRemap = 1'b0;
    wait_core(1'b1);
    expTap = tapPortChooser;
  endtask
  // one bus request, compared with the bench's decode one cycle later
  task automatic bus(input logic [31:0] ad, input logic [1:0] sz, input logic wr, us, df, hit, input logic [2:0] cs);
    int rg;
    logic mis, ab, cn;
    busValid = 1'b1;
    busAddr = ad;
    busSize = sz;
    busWrite = wr;
    busFetch = !wr && ad[2];
    busUserMode = us;
    periphDefined = df;
    extBankHit = hit;
    extBankCs = cs;
    rg = (ad < INT_MEM_TOP) ? 0 : (ad >= EXT_TOP) ? 2 : 1;
    mis = (sz == 2'h1 && ad[0]) || (sz == 2'h2 && ad[1:0] != 2'h0);
    cn = protectEnablePin && protectPinFunc && us && df && rg == 2;
    ab = (rg == 1 && (!hit || (cs != 3'h0 && !expRemap))) || (mis && rg != 2 && !(rg == 0 && !wr));
    @(negedge clk_sys);
    `CHK("accValid", 1'b1, accValid)
    `CHK("region", ({rg == 2, rg == 1, rg == 0, rg == 0 && expRemap, rg == 0 && !expRemap}),
      ({regionPeriph, regionExternal, regionInternal, selSram, selBoot}))
    `CHK("abortPulse", ab, abortPulse)
    `CHK("periphCancel", cn, periphCancel)
    if (ab) begin
      `CHK("abortRecord", ({ad, mis, busFetch}), ({abortAddr, abortMisalign, abortPrefetch}))
    end
  endtask
  task automatic remap(input logic d);
    remapWrite = 1'b1;
    remapData = d;
    @(negedge clk_sys);
    remapWrite = 1'b0;
    repeat (2) @(negedge clk_sys);
    expRemap = d;
    `CHK("remap", ({d, {7{d}}}), ({remapped, csEnable}))
  endtask

  // ************
  // main sequence
  // ************
  initial begin
    repeat (16) @(negedge clk_sys);
    chip_reset_n = 1'b1;
    wait_core(1'b1);
    // every mode code with its straps; later pin changes are ignored
    for (int m = 0; m < 4; m++) begin
      {modePinLow, modePinHigh} = m[1:0];
      bootWidthStrap = m[0];
      tristateStrapN = (m != 3);
      tapPortChooser = m[1];
      pulse(12, 1'b1, 1'b0);
      {modePinLow, modePinHigh} = ~m[1:0];
      repeat (4) @(negedge clk_sys);
      `CHK("modeCode", m[1:0], modeCode)
      `CHK("modeFlags", ({m == 2, m == 1, m == 3, !m[0]}), ({oscBypass, boundaryScanMode, testMode, iceIdNonStd}))
      `CHK("straps", ({m[0], m == 3}), ({bootWidth8, outDriversOff}))
      `CHK("periphClkEn", 1'b1, periphClkEn)
    end
    $display("test modes done");
    // straps: a one-cycle high in the window keeps drivers on
    bootWidthStrap = 1'b1;
    tristateStrapN = 1'b0;
    fork
      pulse(20, 1'b1, 1'b0);
      begin
        repeat (6) @(negedge clk_sys);
        bootWidthStrap = 1'b0;
        repeat (9) @(negedge clk_sys);
        tristateStrapN = 1'b1;
        @(negedge clk_sys);
        tristateStrapN = 1'b0;
      end
    join
    `CHK("straps", 2'h0, ({bootWidth8, outDriversOff}))
    $display("test strap window done");
    // remap opens chip selects; watchdog clears it but keeps straps
    for (int d = 0; d < 2; d++) begin
      remap(d[0]);
      bus(32'h0100_0000, 2'h2, 1'b0, 1'b0, 1'b0, 1'b1, 3'h3);
      bus(32'h0000_0010, 2'h2, 1'b0, 1'b0, 1'b0, 1'b1, 3'h0);
    end
    busValid = 1'b0;
    bootWidthStrap = 1'b1;
    wdResetReq = 1'b1;
    @(negedge clk_sys);
    wdResetReq = 1'b0;
    wait_core(1'b0);
    wait_core(1'b1);
    expRemap = 1'b0;
    `CHK("wdState", 4'h8, ({lastResetWd, bootWidth8, outDriversOff, remapped}))
    pulse(12, 1'b0, 1'b1);
    `CHK("pinWins", 3'h7, ({!lastResetWd, bootWidth8, outDriversOff}))
    $display("test remap and watchdog done");
    // random requests with protection on and off, region edges first
    for (int pe = 1; pe >= 0; pe--) begin
      protectEnablePin = pe[0];
      repeat (4) @(negedge clk_sys);
      for (int i = 0; i < 40; i++) begin
        a = (i < 4) ? edges[i] : $random(seed);
        r = $random(seed);
        if (i >= 4 && r[10:9] == 2'h0) a[31:22] = 10'h0;
        if (i >= 4 && r[10:9] == 2'h1) a[31:22] = 10'h3FF;
        protectPinFunc = r[8];
        bus(a, (r[1:0] == 2'h3) ? 2'h2 : r[1:0], r[2], r[3], r[4], r[11], r[7:5]);
      end
      busValid = 1'b0;
    end
    $display("test bus decode done");
    wrap_up;
  end
endmodule
